// [dpbs_pkg.sv]
// Shared constants of the dual-port burst SRAM link
package dpbs_pkg;
	// Word and array geometry
	localparam int DATA_WIDTH = 18;
	localparam int LANE_WIDTH = 9;
	localparam int LANE_COUNT = 2;
	localparam int ADDR_WIDTH = 18;
	localparam int BURST_WIDTH = 36;
	// Impedance update interval in input clock cycles
	localparam int IMP_INTERVAL = 1024;
	localparam int IMP_CNT_WIDTH = $clog2(IMP_INTERVAL);
	// Host clock divider: one link clock period in system clocks
	localparam int LINK_PHASES = 4;
	localparam logic [1:0] PH_K_RISE = 2'h0;
	localparam logic [1:0] PH_KN_SETUP = 2'h0;
	localparam logic [1:0] PH_LO_SAMPLE = 2'h1;
	localparam logic [1:0] PH_TAKE = 2'h2;
	localparam logic [1:0] PH_HI_SAMPLE = 2'h3;
	// Read data FIFO
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_MARGIN = 4;
endpackage : dpbs_pkg

// [dpbs_link_if.sv]
// Pin-level link between memory controller and SRAM port logic
`timescale 1ns/1ns
interface dpbs_link_if #(parameter int ADDR_W = 18);
	// Input clock pair and output clock pair
	logic kPos;
	logic kNeg;
	logic cPos;
	logic cNeg;
	// Port selects, multiplexed address, write side
	logic readSel_n;
	logic writeSel_n;
	logic [ADDR_W-1:0] addr;
	logic [17:0] wrData;
	logic [1:0] byteEn_n;
	// Read side with output enable
	logic [17:0] rdQ;
	logic rdQOe;

	modport dev (
		input kPos, kNeg, cPos, cNeg, readSel_n, writeSel_n, addr, wrData, byteEn_n,
		output rdQ, rdQOe
	);
	modport host (
		output kPos, kNeg, cPos, cNeg, readSel_n, writeSel_n, addr, wrData, byteEn_n,
		input rdQ, rdQOe
	);
endinterface : dpbs_link_if

// [dpbs_fifo.sv]
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dpbs_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// Free slots
	output logic [$clog2(DEPTH+1)-1:0] freeCount
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
		$error("dpbs_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	// Honest full and empty from the occupancy count
	assign inReady = (count_reg != CW'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rdPtr_reg];
	assign freeCount = CW'(DEPTH) - count_reg;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wrPtr_reg] <= inData;
		end
	end

	// Pointers and count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule : dpbs_fifo

// [dpbs_device.sv]
// Port logic of the dual-port burst SRAM
//
// Function
// - Read starts on K rise, address captured
// - Two 18-bit arrays, two-word bursts
// - Low word on C, high on C-bar
// - Output released after next C rise
// - Write starts on K rise, low word latched
// - K-bar rise: address, high word, write
// - Byte enables sampled with each word
// - Enable 0 lanes 8:0, 1 lanes 17:9
// - Output clocks high at start: single clock
// - Ports independent, same-cycle read and write
// - Read returns newest data, writes committed before fetch
// - Selects sampled on K; pending ops finish
// - Deselected write port ignores its inputs
// - Impedance update every 1024 cycles
// - Read data one cycle after start
// - Reset: deselected, outputs released
// - Both selects high: no operation
`timescale 1ns/1ns
module dpbs_device
	import dpbs_pkg::*;
#(
	parameter int ADDR_W = ADDR_WIDTH
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link pins
	dpbs_link_if.dev link,
	// Status to the surrounding chip
	output logic impUpdate,
	output logic singleClkMode,
	output logic readDriving
);
	if (ADDR_W < 1 || ADDR_W > 20) begin : gBadAddr
		$error("dpbs_device address width must be 1 to 20");
	end

	localparam int WORDS = 1 << ADDR_W;

	////////////////////////////////////////////////////////////////////////////////
	// Storage and state

	logic [DATA_WIDTH-1:0] memLo_reg [WORDS];
	logic [DATA_WIDTH-1:0] memHi_reg [WORDS];
	logic kPosPrev_reg;
	logic kNegPrev_reg;
	logic cPosPrev_reg;
	logic cNegPrev_reg;
	logic strapDone_reg;
	logic singleClk_reg;
	logic rdPend_reg;
	logic [ADDR_W-1:0] rdAddr_reg;
	logic armed_reg;
	logic hiPend_reg;
	logic [DATA_WIDTH-1:0] holdLo_reg;
	logic [DATA_WIDTH-1:0] holdHi_reg;
	logic [DATA_WIDTH-1:0] q_reg;
	logic qOe_reg;
	logic wrPend_reg;
	logic [DATA_WIDTH-1:0] wrLo_reg;
	logic [LANE_COUNT-1:0] wrLoBe_n_reg;
	logic [IMP_CNT_WIDTH-1:0] impCnt_reg;
	logic impUpdate_reg;

	logic kRise;
	logic kNegRise;
	logic oPosRise;
	logic oNegRise;
	logic fetchNow;
	logic commitNow;
	logic [DATA_WIDTH-1:0] fetchLo;
	logic [DATA_WIDTH-1:0] fetchHi;

	////////////////////////////////////////////////////////////////////////////////
	// Clock edge detection

	// Edges of the link clocks; nothing moves without them
	assign kRise = link.kPos && !kPosPrev_reg;
	assign kNegRise = link.kNeg && !kNegPrev_reg;
	// Output timing follows C pair, or K pair in single clock mode
	assign oPosRise = singleClk_reg ? kRise : (link.cPos && !cPosPrev_reg);
	assign oNegRise = singleClk_reg ? kNegRise : (link.cNeg && !cNegPrev_reg);

	// Previous clock levels
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kPosPrev_reg <= 1'b1;
			kNegPrev_reg <= 1'b1;
			cPosPrev_reg <= 1'b1;
			cNegPrev_reg <= 1'b1;
		end else begin
			kPosPrev_reg <= link.kPos;
			kNegPrev_reg <= link.kNeg;
			cPosPrev_reg <= link.cPos;
			cNegPrev_reg <= link.cNeg;
		end
	end

	// Strap caught once after reset release, then frozen
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strapDone_reg <= 1'b0;
			singleClk_reg <= 1'b0;
		end else if (!strapDone_reg) begin
			strapDone_reg <= 1'b1;
			singleClk_reg <= link.cPos && link.cNeg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	// Read start and address capture on K rise only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPend_reg <= 1'b0;
			rdAddr_reg <= '0;
		end else if (kRise) begin
			rdPend_reg <= !link.readSel_n;
			if (!link.readSel_n) begin
				rdAddr_reg <= link.addr;
			end
		end
	end

	// Fetch one cycle after start; writes commit on the K-bar rise in between
	assign fetchNow = kRise && rdPend_reg;
	assign fetchLo = memLo_reg[rdAddr_reg];
	assign fetchHi = memHi_reg[rdAddr_reg];

	// Fetched burst held until the output clocks take it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
			holdLo_reg <= '0;
			holdHi_reg <= '0;
		end else begin
			if (fetchNow) begin
				holdLo_reg <= fetchLo;
				holdHi_reg <= fetchHi;
			end
			if (fetchNow && !oPosRise) begin
				armed_reg <= 1'b1;
			end else if (oPosRise) begin
				armed_reg <= 1'b0;
			end
		end
	end

	// Output register: low word on C, high word on C-bar, release on next C
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_reg <= '0;
			qOe_reg <= 1'b0;
			hiPend_reg <= 1'b0;
		end else if (oPosRise) begin
			if (armed_reg || fetchNow) begin
				q_reg <= fetchNow ? fetchLo : holdLo_reg;
				qOe_reg <= 1'b1;
				hiPend_reg <= 1'b1;
			end else begin
				qOe_reg <= 1'b0;
				hiPend_reg <= 1'b0;
			end
		end else if (oNegRise && hiPend_reg) begin
			q_reg <= holdHi_reg;
			hiPend_reg <= 1'b0;
		end
	end

	assign link.rdQ = q_reg;
	assign link.rdQOe = qOe_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Write port

	// Write start on K rise latches the low word and its enables
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_reg <= 1'b0;
			wrLo_reg <= '0;
			wrLoBe_n_reg <= '1;
		end else if (kRise) begin
			wrPend_reg <= !link.writeSel_n;
			if (!link.writeSel_n) begin
				wrLo_reg <= link.wrData;
				wrLoBe_n_reg <= link.byteEn_n;
			end
		end else if (kNegRise) begin
			wrPend_reg <= 1'b0;
		end
	end

	// Second half only acts when a write is pending
	assign commitNow = kNegRise && wrPend_reg;

	// Array update per byte lane, both words at the K-bar address
	always_ff @(posedge clk) begin
		if (commitNow) begin
			for (int i = 0; i < LANE_COUNT; i++) begin
				if (!wrLoBe_n_reg[i]) begin
					memLo_reg[link.addr][i*LANE_WIDTH +: LANE_WIDTH] <= wrLo_reg[i*LANE_WIDTH +: LANE_WIDTH];
				end
				if (!link.byteEn_n[i]) begin
					memHi_reg[link.addr][i*LANE_WIDTH +: LANE_WIDTH] <= link.wrData[i*LANE_WIDTH +: LANE_WIDTH];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Impedance update timer

	// Counts input clock cycles, so it stands still with the clocks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			impCnt_reg <= '0;
			impUpdate_reg <= 1'b0;
		end else begin
			impUpdate_reg <= 1'b0;
			if (kRise) begin
				impCnt_reg <= impCnt_reg + 1'b1;
				if (impCnt_reg == IMP_CNT_WIDTH'(IMP_INTERVAL - 1)) begin
					impUpdate_reg <= 1'b1;
				end
			end
		end
	end

	// Status outputs
	assign impUpdate = impUpdate_reg;
	assign singleClkMode = singleClk_reg;
	assign readDriving = qOe_reg;
endmodule : dpbs_device

// [dpbs_host.sv]
// Memory controller end of the dual-port burst SRAM link
`timescale 1ns/1ns
module dpbs_host
	import dpbs_pkg::*;
#(
	parameter int ADDR_W = ADDR_WIDTH,
	parameter bit SINGLE_CLK = 1'b0,
	parameter int DEPTH = FIFO_DEPTH
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link pins
	dpbs_link_if.host link,
	// Read requests
	input wire logic rdValid,
	output logic rdReady,
	input wire logic [ADDR_W-1:0] rdAddr,
	// Write requests, byte enables active high, bits 1:0 low word
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [BURST_WIDTH-1:0] wrData,
	input wire logic [2*LANE_COUNT-1:0] wrBe,
	// Read data out of the FIFO
	output logic outValid,
	input wire logic outReady,
	output logic [BURST_WIDTH-1:0] outData
);
	if (DEPTH < 2 * FIFO_MARGIN) begin : gBadDepth
		$error("dpbs_host FIFO too shallow for the read pipeline");
	end

	localparam int CW = $clog2(DEPTH+1);

	logic [1:0] phase_reg;
	logic [1:0] phaseNext;
	logic kPos_reg;
	logic kNeg_reg;
	logic rdSel_n_reg;
	logic wrSel_n_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_WIDTH-1:0] d_reg;
	logic [LANE_COUNT-1:0] be_n_reg;
	logic wrHold_reg;
	logic [ADDR_W-1:0] wrAddrHold_reg;
	logic [DATA_WIDTH-1:0] wrHiHold_reg;
	logic [LANE_COUNT-1:0] wrHiBe_n_reg;
	logic rdReady_reg;
	logic wrReady_reg;
	logic [2:0] rdStage_reg;
	logic [DATA_WIDTH-1:0] capLo_reg;
	logic pushValid_reg;
	logic [BURST_WIDTH-1:0] pushData_reg;
	logic [CW-1:0] freeCount;
	logic rdTake;
	logic wrTake;

	////////////////////////////////////////////////////////////////////////////////
	// Link clock divider

	assign phaseNext = phase_reg + 2'h1;

	// K high in phases 0 and 1, K-bar the complement
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= 2'h3;
			kPos_reg <= 1'b0;
			kNeg_reg <= 1'b1;
		end else begin
			phase_reg <= phaseNext;
			kPos_reg <= (phaseNext == PH_K_RISE) || (phaseNext == PH_LO_SAMPLE);
			kNeg_reg <= (phaseNext == PH_TAKE) || (phaseNext == PH_HI_SAMPLE);
		end
	end

	// Output clocks aligned with K, or tied high as the single clock strap
	assign link.kPos = kPos_reg;
	assign link.kNeg = kNeg_reg;
	assign link.cPos = SINGLE_CLK ? 1'b1 : kPos_reg;
	assign link.cNeg = SINGLE_CLK ? 1'b1 : kNeg_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Request acceptance and pin drive

	assign rdTake = rdValid && rdReady_reg && (phase_reg == PH_TAKE);
	assign wrTake = wrValid && wrReady_reg && (phase_reg == PH_TAKE);

	// Ready offered only in the take phase; reads wait for FIFO room
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdReady_reg <= 1'b0;
			wrReady_reg <= 1'b0;
		end else begin
			rdReady_reg <= (phaseNext == PH_TAKE) && (freeCount >= CW'(FIFO_MARGIN));
			wrReady_reg <= (phaseNext == PH_TAKE);
		end
	end

	// Selects, read address and low word before K; write address and high word before K-bar
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdSel_n_reg <= 1'b1;
			wrSel_n_reg <= 1'b1;
			addr_reg <= '0;
			d_reg <= '0;
			be_n_reg <= '1;
			wrHold_reg <= 1'b0;
			wrAddrHold_reg <= '0;
			wrHiHold_reg <= '0;
			wrHiBe_n_reg <= '1;
		end else if (phase_reg == PH_TAKE) begin
			rdSel_n_reg <= !rdTake;
			wrSel_n_reg <= !wrTake;
			addr_reg <= rdAddr;
			d_reg <= wrData[DATA_WIDTH-1:0];
			be_n_reg <= wrTake ? ~wrBe[LANE_COUNT-1:0] : '1;
			wrHold_reg <= wrTake;
			wrAddrHold_reg <= wrAddr;
			wrHiHold_reg <= wrData[BURST_WIDTH-1:DATA_WIDTH];
			wrHiBe_n_reg <= ~wrBe[2*LANE_COUNT-1:LANE_COUNT];
		end else if (phase_reg == PH_KN_SETUP) begin
			rdSel_n_reg <= 1'b1;
			wrSel_n_reg <= 1'b1;
			addr_reg <= wrAddrHold_reg;
			d_reg <= wrHiHold_reg;
			be_n_reg <= wrHold_reg ? wrHiBe_n_reg : '1;
		end
	end

	assign link.readSel_n = rdSel_n_reg;
	assign link.writeSel_n = wrSel_n_reg;
	assign link.addr = addr_reg;
	assign link.wrData = d_reg;
	assign link.byteEn_n = be_n_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read data capture

	// Three-period pipeline: issued, started, data period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdStage_reg <= '0;
			capLo_reg <= '0;
			pushValid_reg <= 1'b0;
			pushData_reg <= '0;
		end else begin
			pushValid_reg <= 1'b0;
			if (phase_reg == PH_TAKE) begin
				rdStage_reg <= {rdStage_reg[1:0], rdTake};
			end
			if (phase_reg == PH_LO_SAMPLE && rdStage_reg[1]) begin
				capLo_reg <= link.rdQ;
			end
			if (phase_reg == PH_HI_SAMPLE && rdStage_reg[2]) begin
				pushData_reg <= {link.rdQ, capLo_reg};
				pushValid_reg <= 1'b1;
			end
		end
	end

	// Read data FIFO toward the user
	dpbs_fifo #(
		.WIDTH(BURST_WIDTH),
		.DEPTH(DEPTH)
	) uFifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(pushValid_reg),
		.inReady(),
		.inData(pushData_reg),
		.outValid(outValid),
		.outReady(outReady),
		.outData(outData),
		.freeCount(freeCount)
	);

	assign rdReady = rdReady_reg;
	assign wrReady = wrReady_reg;
endmodule : dpbs_host

// [dpbs_link_props.sv]
// Concurrent checks on the pins between host and device
`timescale 1ns/1ns
module dpbs_link_props #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link clocks
	input wire logic kPos,
	input wire logic kNeg,
	input wire logic cPos,
	input wire logic cNeg,
	// Selects and write side
	input wire logic readSel_n,
	input wire logic writeSel_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [17:0] wrData,
	input wire logic [1:0] byteEn_n,
	// Read side
	input wire logic [17:0] rdQ,
	input wire logic rdQOe
);
	logic [3:0] sinceRd_reg;
	logic cPos_reg;
	logic cNeg_reg;
	logic cRise_reg;

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////
	// Cycles since the last read start, saturating
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sinceRd_reg <= 4'hF;
		end else if ($rose(kPos) && !readSel_n) begin
			sinceRd_reg <= 4'h0;
		end else if (sinceRd_reg != 4'hF) begin
			sinceRd_reg <= sinceRd_reg + 4'h1;
		end
	end

	// Marks the cycle after any output clock rise
	always_ff @(posedge clk) begin
		cPos_reg <= cPos;
		cNeg_reg <= cNeg;
		cRise_reg <= (cPos && !cPos_reg) || (cNeg && !cNeg_reg);
	end

	////////////////////////////////////////////////////////////////
	// Properties
	property p_read_drive;
		$rose(kPos) && !readSel_n |-> ##[3:6] rdQOe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read did not drive output");
	property p_release;
		sinceRd_reg > 4'h9 |-> !rdQOe;
	endproperty
	a_release: assert property (p_release) else $error("output not released");
	property p_burst_hold;
		$rose(rdQOe) |-> rdQOe [*4];
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst shorter than two words");
	property p_q_on_edge;
		rdQOe && $past(rdQOe) && $changed(rdQ) |-> cRise_reg;
	endproperty
	a_q_on_edge: assert property (p_q_on_edge) else $error("read data moved off clock edge");
	property p_read_sel;
		$fell(readSel_n) |-> ##[0:2] ($rose(kPos) && !readSel_n);
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("read select missed clock rise");
	property p_write_sel;
		$fell(writeSel_n) |-> ##[0:2] ($rose(kPos) && !writeSel_n);
	endproperty
	a_write_sel: assert property (p_write_sel) else $error("write select missed clock rise");
	property p_clk_mode;
		(cPos == kPos && cNeg == kNeg) || (cPos && cNeg);
	endproperty
	a_clk_mode: assert property (p_clk_mode) else $error("output clocks neither aligned nor strapped");
	property p_k_pair;
		kNeg == !kPos;
	endproperty
	a_k_pair: assert property (p_k_pair) else $error("input clocks not complementary");
	property p_k_period;
		$rose(kPos) |-> ##4 $rose(kPos);
	endproperty
	a_k_period: assert property (p_k_period) else $error("input clock period wrong");
	property p_idle_lanes;
		$rose(kPos) && writeSel_n |-> byteEn_n == 2'h3;
	endproperty
	a_idle_lanes: assert property (p_idle_lanes) else $error("lane enables active without write");

	// Main scenarios
	c_read: cover property ($rose(kPos) && !readSel_n);
	c_write: cover property ($rose(kPos) && !writeSel_n);
	c_both: cover property ($rose(kPos) && !readSel_n && !writeSel_n);
	c_drive: cover property ($rose(rdQOe));
endmodule : dpbs_link_props

// [testbench.sv]
// Self-checking bench joining host and device ends
`timescale 1ns/1ns
module testbench
	import dpbs_pkg::*;
;
	typedef struct packed {
		logic r;
		logic w;
		logic [5:0] ra;
		logic [5:0] wa;
		logic [35:0] d;
		logic [3:0] be;
		logic [35:0] q;
	} dpbs_row_type;
	// Request, then expected read word
	localparam dpbs_row_type ROWS [14] = '{
		'{1'h0, 1'h1, 6'h00, 6'h05, 36'hFFFFFFFFF, 4'hF, 36'h0},
		'{1'h1, 1'h0, 6'h05, 6'h00, 36'h0, 4'h0, 36'hFFFFFFFFF},
		'{1'h0, 1'h1, 6'h00, 6'h05, 36'h0, 4'h1, 36'h0},
		'{1'h1, 1'h0, 6'h05, 6'h00, 36'h0, 4'h0, 36'hFFFFFFE00},
		'{1'h0, 1'h1, 6'h00, 6'h05, 36'h0, 4'h8, 36'h0},
		'{1'h1, 1'h0, 6'h05, 6'h00, 36'h0, 4'h0, 36'h007FFFE00},
		'{1'h0, 1'h1, 6'h00, 6'h05, 36'hFFFFFFFFF, 4'h0, 36'h0},
		'{1'h1, 1'h0, 6'h05, 6'h00, 36'h0, 4'h0, 36'h007FFFE00},
		'{1'h0, 1'h1, 6'h00, 6'h05, 36'h0, 4'h6, 36'h0},
		'{1'h1, 1'h0, 6'h05, 6'h00, 36'h0, 4'h0, 36'h0},
		'{1'h0, 1'h1, 6'h00, 6'h2A, 36'h123456789, 4'hF, 36'h0},
		'{1'h1, 1'h1, 6'h2A, 6'h05, 36'h0F0F0F0F0, 4'hF, 36'h123456789},
		'{1'h1, 1'h1, 6'h05, 6'h05, 36'hFFFFFFFFF, 4'h5, 36'h0F7FCF1FF},
		'{1'h1, 1'h0, 6'h2A, 6'h00, 36'h0, 4'h0, 36'h123456789}
	};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rdValid = 1'b0, wrValid = 1'b0, outReady = 1'b1;
	logic [5:0] rdAddr = 6'h00, wrAddr = 6'h00;
	logic [35:0] wrData = 36'h0;
	logic [3:0] wrBe = 4'h0;
	logic rdReady, wrReady, outValid, impUpdate, singleClkMode, readDriving;
	logic [35:0] outData;
	logic [35:0] expQ [$];
	logic [35:0] expQ2 [$];
	logic outValid2, singleClkMode2;
	logic [35:0] outData2;
	int errors = 0, compares = 0, taken, n;

	////////////////////////////////////////////////////////////////
	// Both ends on one link, checker beside it
	dpbs_link_if #(.ADDR_W(6)) dpbs_link_if_inst ();
	dpbs_device #(.ADDR_W(6)) dpbs_device_inst (.clk(clk), .rst_n(rst_n), .link(dpbs_link_if_inst.dev),
		.impUpdate(impUpdate), .singleClkMode(singleClkMode), .readDriving(readDriving));
	dpbs_host #(.ADDR_W(6)) dpbs_host_inst (.clk(clk), .rst_n(rst_n), .link(dpbs_link_if_inst.host),
		.rdValid(rdValid), .rdReady(rdReady), .rdAddr(rdAddr), .wrValid(wrValid), .wrReady(wrReady),
		.wrAddr(wrAddr), .wrData(wrData), .wrBe(wrBe), .outValid(outValid), .outReady(outReady),
		.outData(outData));
	dpbs_link_props #(.ADDR_W(6)) dpbs_link_props_inst (.clk(clk), .rst_n(rst_n),
		.kPos(dpbs_link_if_inst.kPos), .kNeg(dpbs_link_if_inst.kNeg), .cPos(dpbs_link_if_inst.cPos),
		.cNeg(dpbs_link_if_inst.cNeg), .readSel_n(dpbs_link_if_inst.readSel_n),
		.writeSel_n(dpbs_link_if_inst.writeSel_n), .addr(dpbs_link_if_inst.addr),
		.wrData(dpbs_link_if_inst.wrData), .byteEn_n(dpbs_link_if_inst.byteEn_n),
		.rdQ(dpbs_link_if_inst.rdQ), .rdQOe(dpbs_link_if_inst.rdQOe));

	// Second pair strapped to single clock mode, fed the same requests
	if (1) begin : gSingle
		dpbs_link_if #(.ADDR_W(6)) dpbs_link_if_inst ();
		dpbs_device #(.ADDR_W(6)) dpbs_device_inst (.clk(clk), .rst_n(rst_n), .link(dpbs_link_if_inst.dev),
			.impUpdate(), .singleClkMode(singleClkMode2), .readDriving());
		dpbs_host #(.ADDR_W(6), .SINGLE_CLK(1'b1)) dpbs_host_inst (.clk(clk), .rst_n(rst_n),
			.link(dpbs_link_if_inst.host), .rdValid(rdValid), .rdReady(), .rdAddr(rdAddr),
			.wrValid(wrValid), .wrReady(), .wrAddr(wrAddr), .wrData(wrData), .wrBe(wrBe),
			.outValid(outValid2), .outReady(outReady), .outData(outData2));
	end

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	// Offer one row's requests, hold each until taken
	task automatic go(input dpbs_row_type t);
		logic pr, pw;
		int k;
		@(posedge clk);
		pr = t.r;
		pw = t.w;
		rdValid <= t.r;
		rdAddr <= t.ra;
		wrValid <= t.w;
		wrAddr <= t.wa;
		wrData <= t.d;
		wrBe <= t.be;
		for (k = 0; k < 100 && (pr || pw); k++) begin
			@(posedge clk);
			if (pr && rdReady === 1'b1) begin
				pr = 1'b0;
				rdValid <= 1'b0;
				expQ.push_back(t.q);
				expQ2.push_back(t.q);
			end
			if (pw && wrReady === 1'b1) begin
				pw = 1'b0;
				wrValid <= 1'b0;
			end
		end
		chk(!pr && !pw, "request not taken");
	endtask : go

	task automatic drain();
		int k;
		for (k = 0; k < 100 && (expQ.size() > 0 || expQ2.size() > 0); k++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk(expQ.size() == 0 && expQ2.size() == 0, "read data missing");
	endtask : drain

	task automatic close_out();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Every word leaving the FIFO is compared in order
	always @(posedge clk) begin
		if (rst_n && outValid === 1'b1 && outReady === 1'b1) begin
			chk(expQ.size() > 0 && outData === expQ[0], "read data");
			if (expQ.size() > 0) void'(expQ.pop_front());
		end
	end

	// Same comparison for the single clock pair
	always @(posedge clk) begin
		if (rst_n && outValid2 === 1'b1 && outReady === 1'b1) begin
			chk(expQ2.size() > 0 && outData2 === expQ2[0], "single clock read data");
			if (expQ2.size() > 0) void'(expQ2.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(readDriving === 1'b0 && outValid === 1'b0, "reset state");
		chk(singleClkMode === 1'b0, "clock mode");
		chk(singleClkMode2 === 1'b1, "single clock strap");
		$display("reset test done");
		foreach (ROWS[i]) go(ROWS[i]);
		drain();
		$display("table test done");
		// Stall the drain side until reads are refused
		outReady <= 1'b0;
		rdAddr <= 6'h2A;
		rdValid <= 1'b1;
		taken = 0;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (rdReady === 1'b1) begin
				taken++;
				n = 0;
				expQ.push_back(36'h123456789);
				expQ2.push_back(36'h123456789);
			end
		end
		rdValid <= 1'b0;
		chk(taken >= 12 && taken <= FIFO_DEPTH, "fill count");
		chk(outValid === 1'b1, "fifo holds data");
		outReady <= 1'b1;
		drain();
		chk(outValid === 1'b0, "fifo empty");
		$display("fill test done");
		// Spacing of two impedance updates
		for (n = 0; n < 5000 && impUpdate !== 1'b1; n++) @(posedge clk);
		for (n = 1; n < 5000; n++) begin
			@(posedge clk);
			if (impUpdate === 1'b1) break;
		end
		chk(n == LINK_PHASES * IMP_INTERVAL, "impedance interval");
		$display("impedance test done");
		// Reset in the middle of a read
		go('{1'h1, 1'h0, 6'h2A, 6'h00, 36'h0, 4'h0, 36'h123456789});
		repeat (3) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		expQ.delete();
		expQ2.delete();
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(readDriving === 1'b0 && outValid === 1'b0, "second reset");
		$display("second reset test done");
		close_out();
	end

	// Watchdog
	initial begin
		#(20000 * 10);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule : testbench
